// ---- dv/ebm_monitor.sv ----
`default_nettype none
`include "ebm_consts.svh"

module ebm_monitor (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        ce,
  input wire logic        mode_pin_hi,
  input wire logic        mode_pin_lo,
  input wire logic        waitrequest,
  input wire logic [31:0] readdata,
  input wire logic [31:0] cpu_addr,
  input wire logic [`EBM_EXT_ADDR_W-1:0] ext_addr,
  input wire logic        ext_cycle_go,
  input wire logic        ext_idle_state,
  input wire logic [7:0]  ext_data_wr,
  input wire logic        ext_data_drive,
  input wire logic [7:0]  p3_pin_out,
  input wire logic [7:0]  p3_pin_oe,
  input wire logic        cpu_advanced,
  input wire logic        rom_enable,
  input wire logic        expanded
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // mode decode, five stable edges cover sync and decode delay
  sequence s_mode(logic h, logic l);
    (ce && mode_pin_hi == h && mode_pin_lo == l) [*5];
  endsequence
  sequence s_idle_go;
    ext_idle_state ##1 (ext_cycle_go && !ext_idle_state);
  endsequence

  AST_MODE_ONE: assert property (s_mode(1'b0, 1'b1) |->
    expanded && !rom_enable && !cpu_advanced)
    else $error("mode one outputs wrong");
  AST_MODE_TWO: assert property (s_mode(1'b1, 1'b0) |->
    cpu_advanced && rom_enable)
    else $error("mode two outputs wrong");
  AST_MODE_THREE: assert property (s_mode(1'b1, 1'b1) |->
    !cpu_advanced && rom_enable)
    else $error("mode three outputs wrong");

  // ==========================================================
  // external bus
  AST_ADDR_CUT: assert property ($past(ce) && $past(rst_n) |->
    ext_addr == $past(cpu_addr[23:0]))
    else $error("external address not cut to 24 bits");
  AST_IDLE_GO: assert property (ext_idle_state |-> s_idle_go)
    else $error("idle state not followed by grant");
  AST_SINGLE_CHIP: assert property ((!expanded) [*3] |-> !ext_cycle_go)
    else $error("grant while single chip");
  AST_P3_EXT: assert property (expanded [*2] ##0 ext_data_drive |=>
    p3_pin_oe == 8'hff && p3_pin_out == $past(ext_data_wr))
    else $error("port 3 not external data bus");

  // ==========================================================
  // register bus
  AST_WAIT_PULSE: assert property (!waitrequest && ce |=> waitrequest)
    else $error("waitrequest low too long");
  AST_RD_UPPER: assert property (!waitrequest |-> readdata[31:8] == 24'h0)
    else $error("readdata upper bits set");
endmodule : ebm_monitor

bind external_bus_mode_config ebm_monitor mon (.mclk, .rst_n, .ce,
  .mode_pin_hi, .mode_pin_lo, .waitrequest, .readdata, .cpu_addr, .ext_addr,
  .ext_cycle_go, .ext_idle_state, .ext_data_wr, .ext_data_drive, .p3_pin_out,
  .p3_pin_oe, .cpu_advanced, .rom_enable, .expanded);

`default_nettype wire

// ---- dv/ext_mem.sv ----
`default_nettype none

module ext_mem (
  input wire logic        mclk,
  input wire logic        go,
  input wire logic        rd,
  input wire logic [23:0] addr,
  input wire logic [7:0]  pin_out,
  input wire logic [7:0]  pin_oe,
  output logic     [7:0]  pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [16];
  logic [7:0] last;
  int         hold;
  initial last = 8'h00;
  initial hold = 0;

  // ==========================================================
  // memory side, read data held six cycles after the grant
  always @(posedge mclk) begin
    if (hold > 0) hold <= hold - 1;
    if (go && !rd) mem[addr[3:0]] <= pin_out;
    if (go && rd) begin
      last <= mem[addr[3:0]];
      hold <= 6;
    end
  end
  // released lines show the inverse once the hold ends so stale data never passes
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & (hold > 0 ? last : ~last));
endmodule : ext_mem

`default_nettype wire

// ---- dv/tb_top.sv ----
`default_nettype none
`include "ebm_consts.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, rst_n, ce, read, write, mode_pin_hi, mode_pin_lo;
  logic        hw_standby, slave_mode, ext_cycle_req, ext_cycle_read;
  logic        ext_data_drive, host_data_bus_drive, waitrequest;
  logic        ext_cycle_go, ext_idle_state, cpu_advanced, rom_enable;
  logic        expanded, burst_rom, mode_illegal;
  logic [7:0]  address, ext_data_wr, host_data_bus_wr, p3_pin_in;
  logic [7:0]  p3_pin_out, p3_pin_oe, p3_pin_rd;
  logic [31:0] writedata, cpu_addr, readdata;
  logic [3:0]  byteenable;
  logic [23:0] ext_addr;
  int          mismatches, comparisons;

  external_bus_mode_config DUT (.mclk, .rst_n, .ce, .address, .read, .write,
    .writedata, .byteenable, .readdata, .waitrequest, .mode_pin_hi,
    .mode_pin_lo, .hw_standby, .slave_mode, .cpu_addr, .ext_cycle_req,
    .ext_cycle_read, .ext_data_wr, .ext_data_drive, .host_data_bus_wr,
    .host_data_bus_drive, .p3_pin_in, .p3_pin_out, .p3_pin_oe, .p3_pin_rd,
    .ext_addr, .ext_cycle_go, .ext_idle_state, .cpu_advanced, .rom_enable,
    .expanded, .burst_rom, .mode_illegal);
  ext_mem mem_model (.mclk, .go(ext_cycle_go), .rd(ext_cycle_read),
    .addr(ext_addr), .pin_out(p3_pin_out), .pin_oe(p3_pin_oe),
    .pin_in(p3_pin_in));

  initial mclk = 1'b0;
  always #20 mclk = ~mclk;

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic [7:0] a, input logic wr, input logic [7:0] d,
                     input logic [31:0] exp);
    int n;
    n = 0;
    address <= a;
    writedata <= {24'h0, d};
    write <= wr;
    read <= !wr;
    do begin
      @(posedge mclk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (waitrequest !== 1'b0) mismatches++;
    if (!wr) chk(readdata, exp);
    read <= 1'b0;
    write <= 1'b0;
    @(posedge mclk);
  endtask : bus

  task automatic hold_reset;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (8) @(posedge mclk);
  endtask : hold_reset

  task automatic do_reset(input logic h, input logic l);
    rst_n <= 1'b0;
    mode_pin_hi <= h;
    mode_pin_lo <= l;
    hold_reset;
  endtask : do_reset

  task automatic ext(input logic r, input logic [7:0] d, input logic idle);
    int   n;
    logic seen;
    n = 0;
    seen = 1'b0;
    ext_cycle_req <= 1'b1;
    ext_cycle_read <= r;
    ext_data_wr <= d;
    ext_data_drive <= !r;
    do begin
      @(posedge mclk);
      n++;
      if (ext_idle_state === 1'b1) seen = 1'b1;
    end while (ext_cycle_go !== 1'b1 && n < 20);
    if (ext_cycle_go !== 1'b1) mismatches++;
    ext_cycle_req <= 1'b0;
    ext_data_drive <= 1'b0;
    chk(seen, idle);
    if (r) repeat (4) @(posedge mclk);
    if (r) chk(p3_pin_rd, d);
    @(posedge mclk);
  endtask : ext

  task automatic complete_run;
    if (mismatches == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  // ==========================================================
  // scenarios
  task automatic t_gpio;
    chk({cpu_advanced, rom_enable, expanded, mode_illegal}, 4'b0100);
    bus(`EBM_OFS_STATUS, 1'b0, 8'h00, 32'h02);
    ext_cycle_req <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(ext_cycle_go, 1'b0);
    ext_cycle_req <= 1'b0;
    bus(`EBM_OFS_P3_DIR, 1'b1, 8'h0f, 32'h0);
    bus(`EBM_OFS_P3_DATA, 1'b1, 8'ha5, 32'h0);
    repeat (2) @(posedge mclk);
    chk({p3_pin_oe, p3_pin_out & 8'h0f}, 16'h0f05);
  endtask : t_gpio

  task automatic t_host;
    bus(`EBM_OFS_P3_DATA, 1'b1, 8'h00, 32'h0);
    bus(`EBM_OFS_P3_DIR, 1'b1, 8'h00, 32'h0);
    bus(`EBM_OFS_SYS_CTL_TWO, 1'b1, 8'h01, 32'h0);
    slave_mode <= 1'b1;
    host_data_bus_drive <= 1'b1;
    host_data_bus_wr <= 8'h3c;
    repeat (3) @(posedge mclk);
    chk({p3_pin_oe, p3_pin_out}, 16'hff3c);
    slave_mode <= 1'b0;
    host_data_bus_drive <= 1'b0;
    bus(`EBM_OFS_SYS_CTL_TWO, 1'b1, 8'h00, 32'h0);
  endtask : t_host

  task automatic t_regs;
    bus(`EBM_OFS_BUS_CONTROL, 1'b0, 8'h00, 32'hd7);
    bus(`EBM_OFS_BUS_CONTROL, 1'b1, 8'hba, 32'h0);
    bus(`EBM_OFS_BUS_CONTROL, 1'b0, 8'h00, 32'hba);
    chk(burst_rom, 1'b1);
    bus(8'h3c, 1'b0, 8'h00, 32'h0);
  endtask : t_regs

  task automatic t_standby;
    hw_standby <= 1'b1;
    repeat (4) @(posedge mclk);
    hw_standby <= 1'b0;
    repeat (4) @(posedge mclk);
    bus(`EBM_OFS_BUS_CONTROL, 1'b0, 8'h00, 32'hd7);
    chk(burst_rom, 1'b0);
  endtask : t_standby

  task automatic t_expand;
    cpu_addr <= 32'hff12_3453;
    bus(`EBM_OFS_MODE_CONTROL, 1'b1, 8'h80, 32'h0);
    repeat (2) @(posedge mclk);
    chk({expanded, ext_addr}, 25'h112_3453);
    bus(`EBM_OFS_MODE_CONTROL, 1'b0, 8'h00, 32'h83);
    bus(`EBM_OFS_STATUS, 1'b0, 8'h00, 32'h46);
    ext(1'b0, 8'h5a, 1'b0);
    ext(1'b1, 8'h5a, 1'b1);
    ext(1'b0, 8'hc3, 1'b1);
    bus(`EBM_OFS_BUS_CONTROL, 1'b1, 8'h97, 32'h0);
    ext(1'b1, 8'hc3, 1'b0);
    ext(1'b0, 8'h69, 1'b0);
  endtask : t_expand

  task automatic t_modes;
    do_reset(1'b0, 1'b1);
    chk({cpu_advanced, rom_enable, expanded, mode_illegal}, 4'b0010);
    bus(`EBM_OFS_BUS_CONTROL, 1'b0, 8'h00, 32'hd7);
    bus(`EBM_OFS_MODE_CONTROL, 1'b1, 8'h00, 32'h0);
    bus(`EBM_OFS_MODE_CONTROL, 1'b0, 8'h00, 32'h01);
    ext(1'b0, 8'h96, 1'b0);
    ext(1'b1, 8'h96, 1'b1);
    do_reset(1'b1, 1'b0);
    chk({cpu_advanced, rom_enable, expanded, mode_illegal}, 4'b1100);
  endtask : t_modes

  initial begin
    {rst_n, ce, read, write, hw_standby, slave_mode} = 6'b010000;
    {mode_pin_hi, mode_pin_lo, ext_cycle_req, ext_cycle_read} = 4'b1100;
    {ext_data_drive, host_data_bus_drive, byteenable} = 6'h01;
    {address, ext_data_wr, host_data_bus_wr} = 24'h0;
    {writedata, cpu_addr} = 64'h0;
    mismatches = 0;
    comparisons = 0;
    hold_reset;
    t_gpio;
    t_host;
    t_regs;
    t_standby;
    t_expand;
    t_modes;
    complete_run;
  end

  initial begin
    repeat (5000) @(posedge mclk);
    mismatches++;
    complete_run;
  end
endmodule : tb_top

`default_nettype wire

// ---- logic/ebm_consts.svh ----
`ifndef EBM_CONSTS_SVH
`define EBM_CONSTS_SVH

// ==========================================================================
// register byte offsets
`define EBM_OFS_BUS_CONTROL   8'h00
`define EBM_OFS_MODE_CONTROL  8'h04
`define EBM_OFS_SYS_CTL_TWO   8'h08
`define EBM_OFS_P3_DATA       8'h0c
`define EBM_OFS_P3_DIR        8'h10
`define EBM_OFS_STATUS        8'h14

// ==========================================================================
// reset values
`define EBM_BUS_CONTROL_RST   8'hd7
`define EBM_P3_RST            8'h00

// ==========================================================================
// field positions
`define EBM_BCR_IDLE_RSVD     7
`define EBM_BCR_IDLE_RW       6
`define EBM_BCR_BURST_ROM     5
`define EBM_MODE_CONTROL_REG_EXPANSION_ENABLE         7
`define EBM_SYS2_HIE          0
`define EBM_EXT_ADDR_W        24

`endif

// ---- logic/ebm_pkg.sv ----
`default_nettype none

package ebm_pkg;

  // ==========================================================================
  // port 3 pin function
  typedef enum logic [1:0] {
    p3_gpio      = 2'b00,
    p3_ext_data  = 2'b01,
    p3_host_data = 2'b11
  } p3_func_e;

  // ==========================================================================
  // direction of the last external bus cycle
  typedef enum logic [1:0] {
    last_none  = 2'b00,
    last_read  = 2'b01,
    last_write = 2'b11
  } last_cycle_e;

  // ==========================================================================
  // register bus answer sequence
  typedef enum logic [1:0] {
    bus_idle   = 2'b00,
    bus_answer = 2'b01
  } bus_state_e;

endpackage : ebm_pkg

`default_nettype wire

// ---- logic/external_bus_mode_config.sv ----
// Notes on behaviour
// R1: mode pins 0,1 give normal cpu, rom off, expanded operation.
// R2: pins 1,0 advanced, 1,1 normal; rom on, single-chip after reset.
// R3: in modes 2 and 3 setting expansion_enable switches to expanded.
// R4: board selects modes 1 to 3 only, pins held steady meanwhile.
// R5: external address space is cut to 16 megabytes.
// R6: bus_control loads d7 on reset and hardware standby only.
// R7: software never writes 0 to bus_control bit 7.
// R8: bit 6 set inserts one idle state between read and write cycles.
// R9: bit 5 picks basic (0) or burst rom (1) interface for all space.
// R10: expanded operation makes port 3 the external data bus.
// R11: single-chip, host enable and slave mode make port 3 host bus.
// R12: otherwise port 3 is gpio, direction bit 1 output, 0 input.
// R13: other bus_control bits are plain storage with their reset values.
`default_nettype none
`include "ebm_consts.svh"

module external_bus_mode_config (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        mode_pin_hi,
  input  wire logic        mode_pin_lo,
  input  wire logic        hw_standby,
  input  wire logic        slave_mode,
  input  wire logic [31:0] cpu_addr,
  input  wire logic        ext_cycle_req,
  input  wire logic        ext_cycle_read,
  input  wire logic [7:0]  ext_data_wr,
  input  wire logic        ext_data_drive,
  input  wire logic [7:0]  host_data_bus_wr,
  input  wire logic        host_data_bus_drive,
  input  wire logic [7:0]  p3_pin_in,
  output logic      [7:0]  p3_pin_out,
  output logic      [7:0]  p3_pin_oe,
  output logic      [7:0]  p3_pin_rd,
  output logic      [`EBM_EXT_ADDR_W-1:0] ext_addr,
  output logic             ext_cycle_go,
  output logic             ext_idle_state,
  output logic             cpu_advanced,
  output logic             rom_enable,
  output logic             expanded,
  output logic             burst_rom,
  output logic             mode_illegal
);

  // ==========================================================================
  // pin synchronisers
  logic [1:0] mode_meta;
  logic [1:0] mode_sync;
  logic       stby_meta;
  logic       stby_sync;
  logic [7:0] p3_meta;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_meta <= 2'h0;
      mode_sync <= 2'h0;
      stby_meta <= 1'b0;
      stby_sync <= 1'b0;
      p3_meta   <= 8'h00;
      p3_pin_rd <= 8'h00;
    end else if (ce) begin
      mode_meta <= {mode_pin_hi, mode_pin_lo};
      mode_sync <= mode_meta;
      stby_meta <= hw_standby;
      stby_sync <= stby_meta;
      p3_meta   <= p3_pin_in;
      p3_pin_rd <= p3_meta;
    end
  end

  // ==========================================================================
  // register bus
  ebm_pkg::bus_state_e bus_state;
  ebm_pkg::bus_state_e next_bus_state;
  logic [7:0]  bus_control;
  logic [7:0]  next_bus_control;
  logic        expansion_enable;
  logic        next_expansion_enable;
  logic        host_iface_enable;
  logic        next_host_iface_enable;
  logic [7:0]  port_three_data;
  logic [7:0]  next_port_three_data;
  logic [7:0]  port_three_direction;
  logic [7:0]  next_port_three_direction;
  logic [31:0] next_readdata;
  logic        next_waitrequest;
  logic        wr_take;
  logic [7:0]  status_word;
  logic        single_chip_mode;
  ebm_pkg::p3_func_e p3_func;

  // modes 2 and 3 are the only ones with a single-chip phase
  assign single_chip_mode = mode_sync[1];
  assign wr_take = write && !waitrequest && byteenable[0];
  assign status_word = {p3_func, 2'b00, mode_illegal, expanded,
                        rom_enable, cpu_advanced};

  always_comb begin
    next_bus_state            = bus_state;
    next_waitrequest          = 1'b1;
    next_readdata             = readdata;
    next_bus_control          = bus_control;
    next_expansion_enable     = expansion_enable;
    next_host_iface_enable    = host_iface_enable;
    next_port_three_data      = port_three_data;
    next_port_three_direction = port_three_direction;
    unique case (bus_state)
      ebm_pkg::bus_idle: begin
        if (read || write) begin
          next_bus_state   = ebm_pkg::bus_answer;
          next_waitrequest = 1'b0;
          next_readdata    = 32'h0;
          unique case (address)
            `EBM_OFS_BUS_CONTROL:
              next_readdata[7:0] = bus_control;
            `EBM_OFS_MODE_CONTROL:
              next_readdata[7:0] = {expansion_enable, 5'h00, mode_sync};
            `EBM_OFS_SYS_CTL_TWO:
              next_readdata[7:0] = {7'h00, host_iface_enable};
            `EBM_OFS_P3_DATA:
              next_readdata[7:0] = port_three_data;
            `EBM_OFS_P3_DIR:
              next_readdata[7:0] = port_three_direction;
            `EBM_OFS_STATUS:
              next_readdata[7:0] = status_word;
            default:
              next_readdata = 32'h0;
          endcase
        end
      end
      ebm_pkg::bus_answer: begin
        next_bus_state = ebm_pkg::bus_idle;
        if (wr_take) begin
          unique case (address)
            `EBM_OFS_BUS_CONTROL:
              next_bus_control = writedata[7:0];     // see R13
            `EBM_OFS_MODE_CONTROL:
              if (single_chip_mode)
                next_expansion_enable = writedata[`EBM_MODE_CONTROL_REG_EXPANSION_ENABLE]; // see R3
            `EBM_OFS_SYS_CTL_TWO:
              next_host_iface_enable = writedata[`EBM_SYS2_HIE];
            `EBM_OFS_P3_DATA:
              next_port_three_data = writedata[7:0];
            `EBM_OFS_P3_DIR:
              next_port_three_direction = writedata[7:0];
            default: begin
            end
          endcase
        end
      end
      default: next_bus_state = ebm_pkg::bus_idle;
    endcase
    // hardware standby reloads bus_control; software standby has no input
    if (stby_sync)
      next_bus_control = `EBM_BUS_CONTROL_RST;       // see R6
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus_state            <= ebm_pkg::bus_idle;
      waitrequest          <= 1'b1;
      readdata             <= 32'h0;
      bus_control          <= `EBM_BUS_CONTROL_RST;  // see R6
      expansion_enable     <= 1'b0;
      host_iface_enable    <= 1'b0;
      port_three_data      <= `EBM_P3_RST;
      port_three_direction <= `EBM_P3_RST;
    end else if (ce) begin
      bus_state            <= next_bus_state;
      waitrequest          <= next_waitrequest;
      readdata             <= next_readdata;
      bus_control          <= next_bus_control;
      expansion_enable     <= next_expansion_enable;
      host_iface_enable    <= next_host_iface_enable;
      port_three_data      <= next_port_three_data;
      port_three_direction <= next_port_three_direction;
    end
  end

  // ==========================================================================
  // mode decode
  ebm_pkg::p3_func_e next_p3_func;
  logic next_cpu_advanced;
  logic next_rom_enable;
  logic next_expanded;
  logic next_mode_illegal;

  always_comb begin
    next_mode_illegal = 1'b0;
    unique case (mode_sync)
      2'b01: begin
        next_cpu_advanced = 1'b0;                    // see R1
        next_rom_enable   = 1'b0;
        next_expanded     = 1'b1;
      end
      2'b10: begin
        next_cpu_advanced = 1'b1;                    // see R2
        next_rom_enable   = 1'b1;
        next_expanded     = expansion_enable;        // see R3
      end
      2'b11: begin
        next_cpu_advanced = 1'b0;                    // see R2
        next_rom_enable   = 1'b1;
        next_expanded     = expansion_enable;        // see R3
      end
      default: begin
        // the board must never strap this; stay single-chip and flag it
        next_cpu_advanced = 1'b0;                    // see R4
        next_rom_enable   = 1'b1;
        next_expanded     = 1'b0;
        next_mode_illegal = 1'b1;
      end
    endcase
    if (next_expanded)
      next_p3_func = ebm_pkg::p3_ext_data;           // see R10
    else if (host_iface_enable && slave_mode)
      next_p3_func = ebm_pkg::p3_host_data;          // see R11
    else
      next_p3_func = ebm_pkg::p3_gpio;               // see R12
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_advanced <= 1'b0;
      rom_enable   <= 1'b1;
      expanded     <= 1'b0;
      mode_illegal <= 1'b0;
      p3_func      <= ebm_pkg::p3_gpio;
      burst_rom    <= 1'b0;
      ext_addr     <= '0;
    end else if (ce) begin
      cpu_advanced <= next_cpu_advanced;
      rom_enable   <= next_rom_enable;
      expanded     <= next_expanded;
      mode_illegal <= next_mode_illegal;
      p3_func      <= next_p3_func;
      burst_rom    <= bus_control[`EBM_BCR_BURST_ROM];  // see R9
      // upper address bits never leave the chip
      ext_addr     <= cpu_addr[`EBM_EXT_ADDR_W-1:0];    // see R5
    end
  end

  // ==========================================================================
  // idle state insertion between external cycles of opposite direction
  ebm_pkg::last_cycle_e last_cycle;
  ebm_pkg::last_cycle_e next_last_cycle;
  logic next_cycle_go;
  logic next_idle_state;
  logic dir_change;

  assign dir_change =
    (last_cycle == ebm_pkg::last_read  && !ext_cycle_read) ||
    (last_cycle == ebm_pkg::last_write &&  ext_cycle_read);

  always_comb begin
    next_last_cycle = last_cycle;
    next_cycle_go   = 1'b0;
    next_idle_state = 1'b0;
    // requester drops its request after seeing go, so skip that cycle
    if (ext_cycle_req && !ext_cycle_go && expanded) begin
      if (bus_control[`EBM_BCR_IDLE_RW] && dir_change && !ext_idle_state)
        next_idle_state = 1'b1;                      // see R8
      else begin
        next_cycle_go   = 1'b1;
        next_last_cycle = ext_cycle_read ? ebm_pkg::last_read
                                         : ebm_pkg::last_write;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      last_cycle     <= ebm_pkg::last_none;
      ext_cycle_go   <= 1'b0;
      ext_idle_state <= 1'b0;
    end else if (ce) begin
      last_cycle     <= next_last_cycle;
      ext_cycle_go   <= next_cycle_go;
      ext_idle_state <= next_idle_state;
    end
  end

  // ==========================================================================
  // port 3 pins
  port_three_if p3 ();

  assign p3.func      = p3_func;
  assign p3.gpio_data = port_three_data;
  assign p3.gpio_dir  = port_three_direction;
  assign p3.ext_dout  = ext_data_wr;
  assign p3.ext_oe    = ext_data_drive;
  assign p3.host_dout = host_data_bus_wr;
  assign p3.host_oe   = host_data_bus_drive;
  assign p3_pin_out   = p3.pin_out;
  assign p3_pin_oe    = p3.pin_oe;

  port_three_mux u_port_three_mux (
    .mclk  (mclk),
    .rst_n (rst_n),
    .ce    (ce),
    .p3    (p3.mux)
  );

endmodule : external_bus_mode_config

`default_nettype wire

// ---- logic/port_three_if.sv ----
`default_nettype none

interface port_three_if;
  ebm_pkg::p3_func_e func;
  logic [7:0]        gpio_data;
  logic [7:0]        gpio_dir;
  logic [7:0]        ext_dout;
  logic              ext_oe;
  logic [7:0]        host_dout;
  logic              host_oe;
  logic [7:0]        pin_out;
  logic [7:0]        pin_oe;

  modport ctrl (
    output func,
    output gpio_data,
    output gpio_dir,
    output ext_dout,
    output ext_oe,
    output host_dout,
    output host_oe,
    input  pin_out,
    input  pin_oe
  );

  modport mux (
    input  func,
    input  gpio_data,
    input  gpio_dir,
    input  ext_dout,
    input  ext_oe,
    input  host_dout,
    input  host_oe,
    output pin_out,
    output pin_oe
  );
endinterface : port_three_if

`default_nettype wire

// ---- logic/port_three_mux.sv ----
`default_nettype none

module port_three_mux (
  input wire logic    mclk,
  input wire logic    rst_n,
  input wire logic    ce,
  port_three_if.mux   p3
);

  logic [7:0] next_pin_out;
  logic [7:0] next_pin_oe;
  logic [7:0] pin_out_q;
  logic [7:0] pin_oe_q;

  // ==========================================================================
  // pin steering
  always_comb begin
    unique case (p3.func)
      ebm_pkg::p3_ext_data: begin
        next_pin_out = p3.ext_dout;                 // see R10
        next_pin_oe  = {8{p3.ext_oe}};
      end
      ebm_pkg::p3_host_data: begin
        next_pin_out = p3.host_dout;                // see R11
        next_pin_oe  = {8{p3.host_oe}};
      end
      default: begin
        next_pin_out = p3.gpio_data;
        next_pin_oe  = p3.gpio_dir;                 // see R12
      end
    endcase
  end

  // registered so the pins never glitch while the function changes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out_q <= 8'h00;
      pin_oe_q  <= 8'h00;
    end else if (ce) begin
      pin_out_q <= next_pin_out;
      pin_oe_q  <= next_pin_oe;
    end
  end

  assign p3.pin_out = pin_out_q;
  assign p3.pin_oe  = pin_oe_q;

endmodule : port_three_mux

`default_nettype wire
